// ---- rtl/aod_decoder.sv ----
// arithmetic opcode decoder with execution clock counts
`timescale 1ns/1ns
module aod_decoder (
  input  wire logic             core_clk,     // core clock, 25 MHz
  input  wire logic             sys_rst,      // synchronous reset, high
  input  wire logic             narrowBus,    // 1: 8-bit bus variant
  input  wire logic             opValid,      // opcode and modrm present
  input  wire logic [7:0]       opcode,       // first instruction byte
  input  wire logic [7:0]       modrm,        // second byte when used
  output logic                  decValid,     // decode result valid
  output aod_pkg::aod_op_t      decOp,        // decoded operation
  output logic                  segOverride,  // prefix decoded
  output aod_pkg::aod_seg_t     segSel,       // which segment prefix
  output logic                  wordOp,       // 1: word operand
  output logic                  regIsDest,    // 1: reg field is target
  output logic                  signExtImm,   // 8-bit immediate widened
  output logic                  memOperand,   // memory operand form
  output logic                  immForm,      // immediate operand form
  output logic [7:0]            clkMin,       // least execution clocks
  output logic [7:0]            clkMax        // most execution clocks
);
  // ---------------------------------------------------------------------
  // combinational decode
  // ---------------------------------------------------------------------
  aod_pkg::aod_op_t  op;
  aod_pkg::aod_seg_t seg;
  logic              isSeg;
  logic              w;
  logic              d;
  logic              s;
  logic              mem;
  logic              imm;
  logic              hasModrm;
  logic [7:0]        cMin;
  logic [7:0]        cMax;
  logic [2:0]        mid;

  // field split of the two bytes
  assign mid = modrm[5:3];
  assign mem = hasModrm && (modrm[7:6] != aod_pkg::MOD_REG);

  // opcode class, flags and base counts
  always_comb begin
    op       = aod_pkg::OP_NONE;
    seg      = aod_pkg::SEG_CODE;
    isSeg    = 1'b0;
    w        = opcode[0];
    d        = 1'b0;
    s        = 1'b0;
    imm      = 1'b0;
    hasModrm = 1'b0;
    cMin     = 8'h00;
    cMax     = 8'h00;
    if (opcode == aod_pkg::OP_CODE_SEG ||
        opcode == aod_pkg::OP_STACK_SEG ||
        opcode == aod_pkg::OP_DATA_SEG ||
        opcode == aod_pkg::OP_EXTRA_SEG) begin
      op    = aod_pkg::OP_SEG_OVERRIDE;
      isSeg = 1'b1;
      // prefix field order differs from the segment enum order
      unique case (opcode)
        aod_pkg::OP_CODE_SEG:  seg = aod_pkg::SEG_CODE;
        aod_pkg::OP_STACK_SEG: seg = aod_pkg::SEG_STACK;
        aod_pkg::OP_DATA_SEG:  seg = aod_pkg::SEG_DATA;
        aod_pkg::OP_EXTRA_SEG: seg = aod_pkg::SEG_EXTRA;
      endcase
      w     = 1'b0;
      cMin  = aod_pkg::CLK_SEG;
    end else if (opcode == aod_pkg::OP_ASC_SUM) begin
      op = aod_pkg::OP_ASCII_ADJUST_AFTER_SUM;
      w = 1'b0;
      cMin = aod_pkg::CLK_ASC_SUM;
    end else if (opcode == aod_pkg::OP_DEC_SUM) begin
      op = aod_pkg::OP_DECIMAL_ADJUST_AFTER_SUM;
      w = 1'b0;
      cMin = aod_pkg::CLK_DEC_ADJ;
    end else if (opcode == aod_pkg::OP_ASC_DIFF) begin
      op = aod_pkg::OP_ASCII_ADJUST_AFTER_DIFFERENCE;
      w = 1'b0;
      cMin = aod_pkg::CLK_ASC_DIFF;
    end else if (opcode == aod_pkg::OP_DEC_DIFF) begin
      op = aod_pkg::OP_DECIMAL_ADJUST_AFTER_DIFFERENCE;
      w = 1'b0;
      cMin = aod_pkg::CLK_DEC_ADJ;
    end else if (opcode[7:2] == aod_pkg::HI_SUM_RM ||
                 opcode[7:2] == aod_pkg::HI_SUMC_RM ||
                 opcode[7:2] == aod_pkg::HI_DIFF_RM ||
                 opcode[7:2] == aod_pkg::HI_BORR_RM) begin
      hasModrm = 1'b1;
      d = opcode[1];
      unique case (opcode[7:2])
        aod_pkg::HI_SUM_RM:  op = aod_pkg::OP_SUM;
        aod_pkg::HI_SUMC_RM: op = aod_pkg::OP_SUM_CARRY;
        aod_pkg::HI_DIFF_RM: op = aod_pkg::OP_DIFF;
        default:             op = aod_pkg::OP_MINUS_WITH_BORROW;
      endcase
      cMin = (modrm[7:6] == aod_pkg::MOD_REG) ? aod_pkg::CLK_RR
                                              : aod_pkg::CLK_RM;
    end else if (opcode[7:1] == aod_pkg::HI_SUM_ACC ||
                 opcode[7:1] == aod_pkg::HI_SUMC_ACC ||
                 opcode[7:1] == aod_pkg::HI_DIFF_ACC ||
                 opcode[7:1] == aod_pkg::HI_BORR_ACC) begin
      imm = 1'b1;
      unique case (opcode[7:1])
        aod_pkg::HI_SUM_ACC:  op = aod_pkg::OP_SUM;
        aod_pkg::HI_SUMC_ACC: op = aod_pkg::OP_SUM_CARRY;
        aod_pkg::HI_DIFF_ACC: op = aod_pkg::OP_DIFF;
        default:              op = aod_pkg::OP_MINUS_WITH_BORROW;
      endcase
      cMin = opcode[0] ? aod_pkg::CLK_ACC_W : aod_pkg::CLK_ACC_B;
    end else if (opcode[7:2] == aod_pkg::HI_IMM_GRP) begin
      hasModrm = 1'b1;
      imm = 1'b1;
      s = opcode[1] & opcode[0];
      unique case (mid)
        aod_pkg::MID_SUM:  op = aod_pkg::OP_SUM;
        aod_pkg::MID_SUMC: op = aod_pkg::OP_SUM_CARRY;
        aod_pkg::MID_DIFF: op = aod_pkg::OP_DIFF;
        aod_pkg::MID_BORR: op = aod_pkg::OP_MINUS_WITH_BORROW;
        default:           op = aod_pkg::OP_NONE;
      endcase
      cMin = (modrm[7:6] == aod_pkg::MOD_REG) ? aod_pkg::CLK_IMM_R
                                              : aod_pkg::CLK_IMM_M;
    end else if (opcode[7:1] == aod_pkg::HI_UNARY_GRP) begin
      hasModrm = 1'b1;
      if (mid == aod_pkg::MID_NEG) begin
        op = aod_pkg::OP_NEGATE_TWOS_COMPLEMENT;
        cMin = (modrm[7:6] == aod_pkg::MOD_REG) ? aod_pkg::CLK_RR
                                                : aod_pkg::CLK_RM;
      end else if (mid == aod_pkg::MID_PROD) begin
        op = aod_pkg::OP_UNSIGNED_PRODUCT;
        unique case ({modrm[7:6] != aod_pkg::MOD_REG, opcode[0]})
          2'b00: begin
            cMin = aod_pkg::CLK_PROD_RB_LO;
            cMax = aod_pkg::CLK_PROD_RB_HI;
          end
          2'b01: begin
            cMin = aod_pkg::CLK_PROD_RW_LO;
            cMax = aod_pkg::CLK_PROD_RW_HI;
          end
          2'b10: begin
            cMin = aod_pkg::CLK_PROD_MB_LO;
            cMax = aod_pkg::CLK_PROD_MB_HI;
          end
          default: begin
            cMin = aod_pkg::CLK_PROD_MW_LO;
            cMax = aod_pkg::CLK_PROD_MW_HI;
          end
        endcase
      end
    end
    if (op == aod_pkg::OP_NONE) begin
      hasModrm = 1'b0;
      w = 1'b0;
      imm = 1'b0;
      s = 1'b0;
      cMin = 8'h00;
    end
    // fixed-count forms report equal bounds
    if (cMax == 8'h00) begin
      cMax = cMin;
    end
  end

  // ---------------------------------------------------------------------
  // registered results
  // ---------------------------------------------------------------------
  logic              next_decValid;
  aod_pkg::aod_op_t  next_decOp;
  logic [7:0]        next_clkMin;
  logic [7:0]        next_clkMax;
  logic              next_segOverride;
  aod_pkg::aod_seg_t next_segSel;
  logic              next_wordOp;
  logic              next_regIsDest;
  logic              next_signExtImm;
  logic              next_memOperand;
  logic              next_immForm;
  logic [7:0]        extra;

  // narrow bus penalty on word memory operands; counts assume no waits
  always_comb begin
    extra = (narrowBus && mem && w) ? aod_pkg::CLK_NARROW_ADD
                                    : 8'h00;
    next_decValid = opValid;
    next_decOp    = opValid ? op : aod_pkg::OP_NONE;
    next_clkMin   = opValid ? 8'(cMin + extra) : 8'h00;
    next_clkMax   = opValid ? 8'(cMax + extra) : 8'h00;
    // flags read as zero when no request was taken
    next_segOverride = opValid & isSeg;
    next_segSel      = seg;
    next_wordOp      = opValid & w;
    next_regIsDest   = opValid & d;
    next_signExtImm  = opValid & s;
    next_memOperand  = opValid & mem;
    next_immForm     = opValid & imm;
  end

  // result registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      decValid    <= 1'b0;
      decOp       <= aod_pkg::OP_NONE;
      segOverride <= 1'b0;
      segSel      <= aod_pkg::SEG_CODE;
      wordOp      <= 1'b0;
      regIsDest   <= 1'b0;
      signExtImm  <= 1'b0;
      memOperand  <= 1'b0;
      immForm     <= 1'b0;
      clkMin      <= 8'h00;
      clkMax      <= 8'h00;
    end else begin
      decValid    <= next_decValid;
      decOp       <= next_decOp;
      segOverride <= next_segOverride;
      segSel      <= next_segSel;
      wordOp      <= next_wordOp;
      regIsDest   <= next_regIsDest;
      signExtImm  <= next_signExtImm;
      memOperand  <= next_memOperand;
      immForm     <= next_immForm;
      clkMin      <= next_clkMin;
      clkMax      <= next_clkMax;
    end
  end
endmodule

// ---- rtl/aod_pkg.sv ----
// package with opcode patterns, group fields and clock counts for the decoder
package aod_pkg;
  // ---------------------------------------------------------------------
  // opcode patterns
  // ---------------------------------------------------------------------
  localparam logic [7:0] OP_CODE_SEG    = 8'h2e;
  localparam logic [7:0] OP_STACK_SEG   = 8'h36;
  localparam logic [7:0] OP_DATA_SEG    = 8'h3e;
  localparam logic [7:0] OP_EXTRA_SEG   = 8'h26;
  localparam logic [7:0] OP_ASC_SUM     = 8'h37;
  localparam logic [7:0] OP_DEC_SUM     = 8'h27;
  localparam logic [7:0] OP_ASC_DIFF    = 8'h3f;
  localparam logic [7:0] OP_DEC_DIFF    = 8'h2f;
  localparam logic [5:0] HI_SUM_RM      = 6'h00; // 000000dw
  localparam logic [6:0] HI_SUM_ACC     = 7'h02; // 0000010w
  localparam logic [5:0] HI_SUMC_RM     = 6'h04; // 000100dw
  localparam logic [6:0] HI_SUMC_ACC    = 7'h0a; // 0001010w
  localparam logic [5:0] HI_DIFF_RM     = 6'h0a; // 001010dw
  localparam logic [6:0] HI_DIFF_ACC    = 7'h16; // 0010110w
  localparam logic [5:0] HI_BORR_RM     = 6'h06; // 000110dw
  localparam logic [6:0] HI_BORR_ACC    = 7'h0e; // 0001110w
  localparam logic [5:0] HI_IMM_GRP     = 6'h20; // 100000sw
  localparam logic [6:0] HI_UNARY_GRP   = 7'h7b; // 1111011w
  // ---------------------------------------------------------------------
  // middle field values
  // ---------------------------------------------------------------------
  localparam logic [2:0] MID_SUM        = 3'h0;
  localparam logic [2:0] MID_SUMC       = 3'h2;
  localparam logic [2:0] MID_BORR       = 3'h3;
  localparam logic [2:0] MID_DIFF       = 3'h5;
  localparam logic [2:0] MID_NEG        = 3'h3;
  localparam logic [2:0] MID_PROD       = 3'h4;
  localparam logic [1:0] MOD_REG        = 2'h3;
  // ---------------------------------------------------------------------
  // clock counts (minimum figures; product uses range bounds)
  // ---------------------------------------------------------------------
  localparam logic [7:0] CLK_SEG        = 8'h02;
  localparam logic [7:0] CLK_RR         = 8'h03;
  localparam logic [7:0] CLK_RM         = 8'h0a;
  localparam logic [7:0] CLK_IMM_R      = 8'h04;
  localparam logic [7:0] CLK_IMM_M      = 8'h10;
  localparam logic [7:0] CLK_ACC_B      = 8'h03;
  localparam logic [7:0] CLK_ACC_W      = 8'h04;
  localparam logic [7:0] CLK_ASC_SUM    = 8'h08;
  localparam logic [7:0] CLK_DEC_ADJ    = 8'h04;
  localparam logic [7:0] CLK_ASC_DIFF   = 8'h07;
  localparam logic [7:0] CLK_PROD_RB_LO = 8'h1a; // 26
  localparam logic [7:0] CLK_PROD_RB_HI = 8'h1c; // 28
  localparam logic [7:0] CLK_PROD_RW_LO = 8'h23; // 35
  localparam logic [7:0] CLK_PROD_RW_HI = 8'h25; // 37
  localparam logic [7:0] CLK_PROD_MB_LO = 8'h20; // 32
  localparam logic [7:0] CLK_PROD_MB_HI = 8'h22; // 34
  localparam logic [7:0] CLK_PROD_MW_LO = 8'h29; // 41
  localparam logic [7:0] CLK_PROD_MW_HI = 8'h2b; // 43
  localparam logic [7:0] CLK_NARROW_ADD = 8'h04; // word memory on 8-bit bus
  // ---------------------------------------------------------------------
  // decoded operation classes
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE, OP_SEG_OVERRIDE, OP_SUM, OP_SUM_CARRY, OP_DIFF,
    OP_MINUS_WITH_BORROW, OP_NEGATE_TWOS_COMPLEMENT,
    OP_ASCII_ADJUST_AFTER_SUM, OP_DECIMAL_ADJUST_AFTER_SUM,
    OP_ASCII_ADJUST_AFTER_DIFFERENCE, OP_DECIMAL_ADJUST_AFTER_DIFFERENCE,
    OP_UNSIGNED_PRODUCT
  } aod_op_t;
  typedef enum logic [1:0] {
    SEG_CODE, SEG_STACK, SEG_DATA, SEG_EXTRA
  } aod_seg_t;
endpackage

// ---- tb/aod_props.sv ----
// checker for the arithmetic opcode decoder
`timescale 1ns/1ns
module aod_props (
  input wire logic             core_clk,    // core clock
  input wire logic             sys_rst,     // sync reset
  input wire logic             narrowBus,   // 8-bit bus
  input wire logic             opValid,     // request
  input wire logic [7:0]       opcode,      // first byte
  input wire logic [7:0]       modrm,       // second byte
  input wire aod_pkg::aod_op_t decOp,       // class
  input wire logic             segOverride, // prefix seen
  input wire logic             wordOp,      // word operand
  input wire logic             immForm,     // immediate form
  input wire logic [7:0]       clkMin,      // low count
  input wire logic [7:0]       clkMax       // high count
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // -------------------------------------------------------------
  // request shapes
  // -------------------------------------------------------------
  sequence s_unary;
    opValid && opcode[7:1] == 7'h7b;
  endsequence
  sequence s_arith;
    opValid && opcode[5:3] inside {3'h0, 3'h2, 3'h3, 3'h5};
  endsequence
  // -------------------------------------------------------------
  // decode results one cycle after the request
  // -------------------------------------------------------------
  a_seg_count: assert property (
    opValid && opcode[7:5] == 3'h1 && opcode[2:0] == 3'h6 |=>
    segOverride && clkMin == 8'h02 && clkMax == 8'h02)
    else $error("prefix count wrong");
  a_asc_sum: assert property (opValid && opcode == 8'h37 |=>
    decOp == aod_pkg::OP_ASCII_ADJUST_AFTER_SUM && clkMin == 8'h08)
    else $error("ascii sum adjust wrong");
  a_dec_adjust: assert property (
    opValid && (opcode == 8'h27 || opcode == 8'h2f) |=> clkMax == 8'h04)
    else $error("decimal adjust count wrong");
  a_asc_diff: assert property (opValid && opcode == 8'h3f |=>
    clkMin == 8'h07 && clkMax == 8'h07) else $error("ascii diff wrong");
  a_prod_range: assert property (
    s_unary ##0 modrm[7:3] == 5'h1c |=> clkMax == clkMin + 8'h02 &&
    clkMin == ($past(opcode[0]) ? 8'h23 : 8'h1a))
    else $error("product range wrong");
  a_neg_count: assert property (
    s_unary ##0 modrm[5:3] == 3'h3 |=> clkMin == ($past(modrm[7:6]) ==
    2'h3 ? 8'h03 : ($past(narrowBus && opcode[0]) ? 8'h0e : 8'h0a)))
    else $error("negate count wrong");
  a_acc_width: assert property (
    s_arith ##0 opcode[7:6] == 2'h0 && opcode[2:1] == 2'h2 |=> immForm &&
    wordOp == $past(opcode[0]) && clkMin == ($past(opcode[0]) ? 8'h04 :
    8'h03)) else $error("accumulator form wrong");
  a_grp_reg: assert property (
    opValid && opcode[7:2] == 6'h20 && modrm[7:6] == 2'h3 &&
    modrm[5:3] inside {3'h0, 3'h2, 3'h3, 3'h5} |=> immForm &&
    clkMin == 8'h04) else $error("group immediate wrong");
  a_rm_reg: assert property (
    s_arith ##0 opcode[7:6] == 2'h0 && !opcode[2] && modrm[7:6] == 2'h3
    |=> !immForm && clkMin == 8'h03) else $error("register form wrong");
endmodule
bind aod_decoder aod_props u_props (.core_clk(core_clk), .sys_rst(sys_rst),
  .narrowBus(narrowBus), .opValid(opValid), .opcode(opcode), .modrm(modrm),
  .decOp(decOp), .segOverride(segOverride), .wordOp(wordOp),
  .immForm(immForm), .clkMin(clkMin), .clkMax(clkMax));

// ---- tb/aod_fetch_model.sv ----
// fetch side model handing opcode pairs as if prefetched
`timescale 1ns/1ns
module aod_fetch_model (
  input  wire logic       core_clk,  // core clock
  input  wire logic       reqValid,  // pair to send
  input  wire logic       reqNarrow, // bus variant
  input  wire logic [7:0] reqOp,     // opcode byte
  input  wire logic [7:0] reqModrm,  // second byte
  output logic            opValid,   // pair valid
  output logic            narrowBus, // bus variant
  output logic [7:0]      opcode,    // first byte
  output logic [7:0]      modrm      // second byte
);
  logic [7:0] lastOp;
  logic [7:0] lastMd;
  // keep the last pair so idle bytes differ from it
  always_ff @(posedge core_clk) begin
    if (reqValid) begin
      lastOp <= reqOp;
      lastMd <= reqModrm;
    end
  end
  // both bytes come together with no wait state
  assign opValid   = reqValid;
  assign narrowBus = reqNarrow;
  assign opcode    = reqValid ? reqOp : ~lastOp;
  assign modrm     = reqValid ? reqModrm : ~lastMd;
endmodule

// ---- tb/tb_arith_opcode_decode_timing.sv ----
// self-checking bench for the arithmetic opcode decoder
`timescale 1ns/1ns
module tb_arith_opcode_decode_timing;
  logic              core_clk, sys_rst, reqValid, reqNarrow, opValid;
  logic              narrowBus, decValid, segOverride, wordOp, immForm;
  logic              regIsDest, signExtImm, memOperand;
  logic [7:0]        reqOp, reqModrm, opcode, modrm, clkMin, clkMax;
  aod_pkg::aod_op_t  decOp;
  aod_pkg::aod_seg_t segSel;
  int                error_cnt = 0;
  int                total_checks = 0;
  logic [2:0]        mids [4] = '{3'h0, 3'h2, 3'h5, 3'h3};
  aod_pkg::aod_op_t  ops [4] = '{aod_pkg::OP_SUM, aod_pkg::OP_SUM_CARRY,
    aod_pkg::OP_DIFF, aod_pkg::OP_MINUS_WITH_BORROW};
  aod_fetch_model u_fetch (.core_clk(core_clk), .reqValid(reqValid),
    .reqNarrow(reqNarrow), .reqOp(reqOp), .reqModrm(reqModrm),
    .opValid(opValid), .narrowBus(narrowBus), .opcode(opcode), .modrm(modrm));
  aod_decoder u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .narrowBus(narrowBus), .opValid(opValid), .opcode(opcode), .modrm(modrm),
    .decValid(decValid), .decOp(decOp), .segOverride(segOverride),
    .segSel(segSel), .wordOp(wordOp), .regIsDest(regIsDest),
    .signExtImm(signExtImm), .memOperand(memOperand), .immForm(immForm),
    .clkMin(clkMin), .clkMax(clkMax));
  // -------------------------------------------------------------
  // shared drive and compare tasks
  // -------------------------------------------------------------
  task automatic flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t flag differs", $time);
    end
  endtask
  task automatic send(input logic n, input logic [7:0] op,
                      input logic [7:0] md);
    @(posedge core_clk);
    reqValid <= 1'b1;
    reqNarrow <= n;
    reqOp <= op;
    reqModrm <= md;
    @(posedge core_clk);
    reqValid <= 1'b0;
    #1;
  endtask
  task automatic look(input aod_pkg::aod_op_t op, input logic [7:0] lo, hi);
    flag(decValid === 1'b1 && decOp === op && clkMin === lo, 1'b1);
    flag(clkMax === hi, 1'b1);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_single();
    logic [7:0] c [8] = '{8'h2e, 8'h36, 8'h3e, 8'h26,
                          8'h37, 8'h27, 8'h3f, 8'h2f};
    logic [7:0] n [8] = '{8'h02, 8'h02, 8'h02, 8'h02,
                          8'h08, 8'h04, 8'h07, 8'h04};
    aod_pkg::aod_op_t o [4] = '{aod_pkg::OP_ASCII_ADJUST_AFTER_SUM,
      aod_pkg::OP_DECIMAL_ADJUST_AFTER_SUM,
      aod_pkg::OP_ASCII_ADJUST_AFTER_DIFFERENCE,
      aod_pkg::OP_DECIMAL_ADJUST_AFTER_DIFFERENCE};
    for (int i = 0; i < 8; i++) begin
      send(1'b1, c[i], 8'hff);
      if (i < 4) look(aod_pkg::OP_SEG_OVERRIDE, n[i], n[i]);
      else look(o[i - 4], n[i], n[i]);
      if (i < 4)
        flag(segSel === aod_pkg::aod_seg_t'(i), segOverride);
    end
  endtask
  task automatic t_forms();
    logic [7:0] lo;
    for (int k = 0; k < 64; k++) begin
      lo = k[4] ? (k[5] && k[0] ? 8'h0e : 8'h0a) : 8'h03;
      send(k[5], {2'h0, mids[k[3:2]], 1'b0, k[1], k[0]},
           k[4] ? 8'h07 : 8'hc0);
      look(ops[k[3:2]], lo, lo);
      flag(wordOp, k[0]);
      flag(regIsDest, k[1]);
      flag(memOperand, k[4]);
      flag(immForm, 1'b0);
      lo = 8'h03 + k[0];
      send(k[5], {2'h0, mids[k[3:2]], 2'h2, k[0]}, 8'h55);
      look(ops[k[3:2]], lo, lo);
      flag(immForm, 1'b1);
      lo = k[4] ? (k[5] && k[0] ? 8'h14 : 8'h10) : 8'h04;
      send(k[5], {6'h20, k[1], k[0]},
           {k[4] ? 2'h0 : 2'h3, mids[k[3:2]], 3'h7});
      look(ops[k[3:2]], lo, lo);
      flag(immForm, 1'b1);
      flag(signExtImm, k[1] && k[0]);
    end
  endtask
  task automatic t_unary();
    logic [7:0]       lo;
    logic [7:0]       add;
    aod_pkg::aod_op_t o;
    for (int k = 0; k < 16; k++) begin
      add = (k[2] && k[1] && k[0]) ? 8'h04 : 8'h00;
      if (k[3]) lo = k[1] ? (k[0] ? 8'h29 : 8'h20) : (k[0] ? 8'h23 : 8'h1a);
      else lo = k[1] ? 8'h0a : 8'h03;
      lo = lo + add;
      o = k[3] ? aod_pkg::OP_UNSIGNED_PRODUCT
               : aod_pkg::OP_NEGATE_TWOS_COMPLEMENT;
      send(k[2], {7'h7b, k[0]},
           {k[1] ? 2'h0 : 2'h3, k[3] ? 3'h4 : 3'h3, 3'h1});
      look(o, lo, lo + (k[3] ? 8'h02 : 8'h00));
    end
  endtask
  task automatic t_refuse();
    send(1'b0, 8'h0f, 8'h00);
    look(aod_pkg::OP_NONE, 8'h00, 8'h00);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    reqValid <= 1'b1;
    @(posedge core_clk);
    sys_rst <= 1'b0;
    reqValid <= 1'b0;
    #1;
    flag(decValid || decOp !== aod_pkg::OP_NONE, 1'b0);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    sys_rst = 1'b1;
    reqValid = 1'b0;
    reqNarrow = 1'b0;
    reqOp = 8'h37;
    reqModrm = 8'h00;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_single();
    t_forms();
    t_unary();
    t_refuse();
    end_sim();
  end
endmodule
